// File: logic/bsram_host.sv
// host controller driving a banked asynchronous static memory module
// assumes the module's pins are joined by the bench; data pins are
// three signals; all inputs synchronous to clk_sys
//
// Overview of operation
// - fifteen bit word address shared by banks
// - host drives at most one bank select
// - write strobe stays high through read cycles
// - every cycle lasts at least 120 ns
// - write pulse 80, select 105, setup 50
// - deselect before retention, recover one cycle
// - no access while supply is lowered
`default_nettype none

module bsram_host #(
  parameter int BANKS   = bsram_pkg::BANKS,
  parameter int WADDR_W = bsram_pkg::WADDR_W,
  parameter int DATA_W  = bsram_pkg::DATA_W
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // user request
  input  wire logic                      req_valid,
  input  wire logic                      req_write,
  input  wire logic [bsram_pkg::BADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0]         req_wdata,
  output logic                           req_ready,
  output logic                           rsp_valid,
  output logic [DATA_W-1:0]              rsp_rdata,
  // retention control
  input  wire logic                      retain_req,
  output logic                           retain_ok,
  // memory pins
  output logic [BANKS-1:0]               bank_select_n,
  output logic [WADDR_W-1:0]             word_addr,
  output logic                           write_n,
  output logic                           output_n,
  input  wire logic [DATA_W-1:0]         data_lines_i,
  output logic [DATA_W-1:0]              data_lines_o,
  output logic                           data_lines_oe
);

  // ************************************************************
  // checks
  // ************************************************************
  // the timer must hold the longest count
  if (BANKS != (1 << bsram_pkg::BANK_W) ||
      WADDR_W != bsram_pkg::WADDR_W || DATA_W < 1 ||
      bsram_pkg::CYCLE_CYC >= (1 << bsram_pkg::CNT_W))
  begin
    $error("bsram_host: unsupported geometry");
  end

  localparam int CW = bsram_pkg::CNT_W;
  localparam logic [CW-1:0] RD_CYC  = CW'(bsram_pkg::CYCLE_CYC);
  localparam logic [CW-1:0] WP_CYC  = CW'(bsram_pkg::SEL_VALID_CYC);
  localparam logic [CW-1:0] WE_CYC  = CW'(bsram_pkg::WE_PULSE_CYC);
  localparam logic [CW-1:0] TAIL_CYC =
    CW'(bsram_pkg::CYCLE_CYC - bsram_pkg::SEL_VALID_CYC);
  localparam logic [CW-1:0] FL_CYC  = CW'(bsram_pkg::FLOAT_CYC);
  localparam logic [CW-1:0] RL_CYC  = CW'(bsram_pkg::RET_LEAD_CYC);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    bsram_pkg::bsram_state_e st;
    logic                    tail;
    logic [BANKS-1:0]        sel_n;
    logic [WADDR_W-1:0]      addr;
    logic                    we_n;
    logic                    oe_n;
    logic [DATA_W-1:0]       dout;
    logic                    doe;
    logic                    ready;
    logic                    rvalid;
    logic [DATA_W-1:0]       rdata;
    logic                    ret_ok;
  } bsram_host_s;

  bsram_host_s s_q;
  bsram_host_s s_d;
  logic          t_load;
  logic [CW-1:0] t_val;
  logic          t_done;

  bsram_timer #(
    .CNT_W (CW)
  ) u_timer (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .load     (t_load),
    .load_val (t_val),
    .done     (t_done)
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    s_d        = s_q;
    t_load     = 1'b0;
    t_val      = '0;
    s_d.rvalid = 1'b0;
    unique case (s_q.st)
      bsram_pkg::BSRAM_IDLE:
      begin
        if (retain_req)
        begin
          // deselect all banks before supply drops
          s_d.sel_n = '1;
          s_d.ready = 1'b0;
          s_d.st    = bsram_pkg::BSRAM_RETAIN;
          t_load    = 1'b1;
          t_val     = RL_CYC;
        end
        else if (req_valid && s_q.ready)
        begin
          s_d.ready = 1'b0;
          s_d.addr  = req_addr[WADDR_W-1:0];
          s_d.sel_n = ~(BANKS'(1) << req_addr[bsram_pkg::BADDR_W-1:
                                             WADDR_W]);
          t_load    = 1'b1;
          if (req_write)
          begin
            s_d.oe_n = 1'b1;
            s_d.we_n = 1'b0;
            s_d.dout = req_wdata;
            s_d.doe  = 1'b1;
            s_d.tail = 1'b0;
            s_d.st   = bsram_pkg::BSRAM_WR;
            t_val    = WP_CYC;
          end
          else
          begin
            s_d.we_n = 1'b1;
            s_d.oe_n = 1'b0;
            s_d.st   = bsram_pkg::BSRAM_RD;
            t_val    = RD_CYC;
          end
        end
      end
      bsram_pkg::BSRAM_RD:
      begin
        if (t_done)
        begin
          // sample once the full access time has passed
          s_d.rdata  = data_lines_i;
          s_d.rvalid = 1'b1;
          s_d.oe_n   = 1'b1;
          s_d.sel_n  = '1;
          s_d.st     = bsram_pkg::BSRAM_FLOAT;
          t_load     = 1'b1;
          t_val      = FL_CYC;
        end
      end
      bsram_pkg::BSRAM_WR:
      begin
        if (t_done && !s_q.tail)
        begin
          // strobe held past the pulse and select minimum; the byte
          // has stood far longer than its setup before this edge
          s_d.we_n = 1'b1;
          s_d.tail = 1'b1;
          t_load   = 1'b1;
          t_val    = TAIL_CYC;
        end
        else if (t_done)
        begin
          // data held four edges past the strobe rise
          s_d.doe   = 1'b0;
          s_d.sel_n = '1;
          // ready always returns; idle gives retention priority, so a
          // short retention pulse here cannot leave the host stuck
          s_d.st    = bsram_pkg::BSRAM_IDLE;
          s_d.ready = 1'b1;
        end
      end
      bsram_pkg::BSRAM_FLOAT:
      begin
        // wait for the device to let go of the data lines
        if (t_done)
        begin
          s_d.st    = bsram_pkg::BSRAM_IDLE;
          s_d.ready = 1'b1;
        end
      end
      bsram_pkg::BSRAM_RETAIN:
      begin
        s_d.ret_ok = t_done;
        if (!retain_req)
        begin
          // supply restored: hold off one read cycle time
          s_d.ret_ok = 1'b0;
          s_d.st     = bsram_pkg::BSRAM_RECOVER;
          t_load     = 1'b1;
          t_val      = RD_CYC;
        end
      end
      bsram_pkg::BSRAM_RECOVER:
      begin
        // requests stay refused until the recovery time has passed
        if (t_done)
        begin
          s_d.st    = bsram_pkg::BSRAM_IDLE;
          s_d.ready = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q        <= '0;
      s_q.st     <= bsram_pkg::BSRAM_IDLE;
      s_q.sel_n  <= '1;
      s_q.we_n   <= 1'b1;
      s_q.oe_n   <= 1'b1;
      s_q.ready  <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign req_ready     = s_q.ready;
  assign rsp_valid     = s_q.rvalid;
  assign rsp_rdata     = s_q.rdata;
  assign retain_ok     = s_q.ret_ok;
  assign bank_select_n = s_q.sel_n;
  assign word_addr     = s_q.addr;
  assign write_n       = s_q.we_n;
  assign output_n      = s_q.oe_n;
  assign data_lines_o  = s_q.dout;
  assign data_lines_oe = s_q.doe;

endmodule

`default_nettype wire

// File: logic/bsram_pkg.sv
// package for the banked static memory host controller
// assumes a 250 MHz system clock and a clockless memory module on pins
`default_nettype none

package bsram_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int BANKS      = 8;
  localparam int WADDR_W    = 15;
  localparam int BANK_W     = 3;
  localparam int BADDR_W    = WADDR_W + BANK_W;
  localparam int DATA_W     = 8;

  // ************************************************************
  // timing, ns as printed, then cycles at the system rate
  // ************************************************************
  localparam int CLK_PERIOD_NS    = 4;
  localparam int CYCLE_NS         = 120;
  localparam int WE_PULSE_NS      = 80;
  localparam int SEL_VALID_NS     = 105;
  localparam int DATA_SETUP_NS    = 50;
  localparam int ACCESS_NS        = 120;
  localparam int OE_ACCESS_NS     = 60;
  localparam int FLOAT_NS         = 45;
  localparam int RET_LEAD_NS      = 0;

  // least times round up, at least one cycle
  localparam int CYCLE_CYC     =
    (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_PULSE_CYC  =
    (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_VALID_CYC =
    (SEL_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_CYC =
    (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // the device answers within these; the host waits them out in full
  localparam int ACCESS_CYC    =
    (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_ACCESS_CYC =
    (OE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC     =
    (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RET_LEAD_CYC  = (RET_LEAD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS > 0 ?
                                 (RET_LEAD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS : 1;

  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    BSRAM_IDLE,
    BSRAM_RD,
    BSRAM_WR,
    BSRAM_FLOAT,
    BSRAM_RETAIN,
    BSRAM_RECOVER
  } bsram_state_e;

endpackage

`default_nettype wire

// File: logic/bsram_timer.sv
// down counter used for every pin timing of the host controller
// assumes a load pulse and a single synchronous clock domain
`default_nettype none

module bsram_timer #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  // status
  output logic                  done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } bsram_tmr_s;

  bsram_tmr_s s_q;
  bsram_tmr_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.cnt = load_val;
    end
    else if (s_q.cnt != '0)
    begin
      s_d.cnt = s_q.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // no load term: the sequencer loads on done, so one would close a
  // combinational loop through it
  assign done = (s_q.cnt == '0);

endmodule

`default_nettype wire

// File: tb/bsram_asserts.sv
// checker on the pins of the banked memory host controller
// assumes it is bound into bsram_host; one clock domain
`default_nettype none

module bsram_asserts (
  // clock, reset and user side
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [17:0] req_addr,
  input wire logic        retain_req,
  input wire logic        retain_ok,
  // memory pins
  input wire logic [7:0]  bank_select_n,
  input wire logic [14:0] word_addr,
  input wire logic        write_n,
  input wire logic        output_n,
  input wire logic [7:0]  data_lines_o,
  input wire logic        data_lines_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic        take;
  logic        start;
  logic        idle_q;
  logic [17:0] addr_q;
  logic [7:0]  gap_q;
  assign take = req_valid && req_ready && !retain_req;
  assign start = idle_q && !(&bank_select_n);
  // gap saturates so a long idle never wraps
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      {idle_q, addr_q, gap_q} <= {1'b1, 18'h00000, 8'hff};
    else
      {idle_q, addr_q, gap_q} <= {&bank_select_n, take ? req_addr : addr_q,
        start ? 8'h01 : gap_q + 8'(gap_q != 8'hff)};
  sequence s_hold20; ##19 1'b1; endsequence
  sequence s_hold30; ##29 1'b1; endsequence
  property p_one_sel; $countones(~bank_select_n) <= 1; endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects");
  property p_rd_we; !output_n |-> write_n && !data_lines_oe; endproperty
  a_rd_we: assert property (p_rd_we) else $error("strobe clash");
  property p_pulse; $fell(write_n) |-> !write_n throughout s_hold20;
  endproperty
  a_pulse: assert property (p_pulse) else $error("short pulse");
  property p_setup; $rose(write_n) |-> data_lines_oe && !(&bank_select_n)
    && data_lines_o == $past(data_lines_o, 13); endproperty
  a_setup: assert property (p_setup) else $error("data setup");
  property p_gap; start |-> gap_q >= 8'd30; endproperty
  a_gap: assert property (p_gap) else $error("cycle short");
  property p_retain; retain_ok |-> &bank_select_n && write_n && output_n;
  endproperty
  a_retain: assert property (p_retain) else $error("access held");
  property p_recover; $fell(retain_ok) |-> &bank_select_n throughout s_hold30;
  endproperty
  a_recover: assert property (p_recover) else $error("early use");
  property p_map; take |-> ##[1:2] bank_select_n == ~(8'h01 << addr_q[17:15])
    && word_addr == addr_q[14:0]; endproperty
  a_map: assert property (p_map) else $error("bad bank");
endmodule

`default_nettype wire

// File: tb/bsram_mem_model.sv
// behavioural model of the banked static memory module
// assumes host pins wired straight in; no clock
`default_nettype none

module bsram_mem_model #(
  parameter int DLY_NS = 100
) (
  // selects, address, strobes
  input wire logic [7:0]  bank_select_n,
  input wire logic [14:0] word_addr,
  input wire logic        write_n,
  input wire logic        output_n,
  // data pins
  input wire logic [7:0]  data_lines_o,
  input wire logic        data_lines_oe,
  output logic [7:0]      data_lines
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:262143];
  logic [7:0]  last_q = 8'h00;
  logic        drive;
  logic        late;
  logic [17:0] idx;
  assign idx = {3'($clog2(~bank_select_n)), word_addr};
  // two selects low drive nothing
  assign drive = $countones(~bank_select_n) == 1 && write_n && !output_n;
  assign #(DLY_NS) late = drive; // slow answer
  // released bus shows inverted last value, release at once
  assign data_lines = data_lines_oe ? data_lines_o
    : drive && late ? mem[idx] : ~last_q;
  // late outlives drive; gating with drive keeps the inverted idle
  // value from feeding itself back
  always @(data_lines)
    if (data_lines_oe || (drive && late)) last_q = data_lines;
  always @(posedge write_n) if (!(&bank_select_n)) mem[idx] = data_lines;
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the banked memory host controller
// assumes the memory model and checker are compiled before it
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [17:0] req_addr = 18'h00000;
  logic [7:0]  req_wdata = 8'h00;
  logic        retain_req = 1'b0;
  logic        req_ready, rsp_valid, retain_ok;
  logic        write_n, output_n, data_lines_oe;
  logic [7:0]  rsp_rdata, bank_select_n, data_lines_o, data_lines, sel;
  logic [14:0] word_addr;
  int          bad_count = 0;
  int          checks_done = 0;
  initial forever #2 clk_sys = ~clk_sys;
  bsram_host dut (
    .clk_sys       (clk_sys),
    .nrst          (nrst),
    .req_valid     (req_valid),
    .req_write     (req_write),
    .req_addr      (req_addr),
    .req_wdata     (req_wdata),
    .req_ready     (req_ready),
    .rsp_valid     (rsp_valid),
    .rsp_rdata     (rsp_rdata),
    .retain_req    (retain_req),
    .retain_ok     (retain_ok),
    .bank_select_n (bank_select_n),
    .word_addr     (word_addr),
    .write_n       (write_n),
    .output_n      (output_n),
    .data_lines_i  (data_lines),
    .data_lines_o  (data_lines_o),
    .data_lines_oe (data_lines_oe)
  );
  bsram_mem_model model (
    .bank_select_n (bank_select_n),
    .word_addr     (word_addr),
    .write_n       (write_n),
    .output_n      (output_n),
    .data_lines_o  (data_lines_o),
    .data_lines_oe (data_lines_oe),
    .data_lines    (data_lines)
  );

  task automatic chk(string what, logic [17:0] exp, logic [17:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one request; sel holds the selects seen early in the access
  task automatic access(logic wr, logic [17:0] a, logic [7:0] d);
    int n = 0;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n++ < 200)
      @(negedge clk_sys);
    chk("ready", 18'h1, 18'(req_ready));
    {req_write, req_addr, req_wdata, req_valid} = {wr, a, d, 1'b1};
    @(negedge clk_sys);
    req_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    sel = bank_select_n;
    while (!wr && rsp_valid !== 1'b1 && n++ < 400)
      @(negedge clk_sys);
    if (!wr)
      chk("read done", 18'h1, 18'(rsp_valid));
  endtask

  task automatic t_idle;
    logic [11:0] pins;
    pins = {bank_select_n, write_n, output_n, data_lines_oe, req_ready};
    chk("idle pins", 18'hffd, 18'(pins));
    $display("test idle done");
  endtask

  // both ends of every bank, written back to back, then read
  task automatic t_banks;
    for (int b = 0; b < 8; b++)
    begin
      access(1'b1, {b[2:0], 15'h7fff}, 8'ha0 + 8'(b));
      chk("write select", 8'(~(8'h01 << b)), sel);
      access(1'b1, {b[2:0], 15'h0000}, 8'h5f ^ 8'(b));
    end
    for (int b = 0; b < 8; b++)
    begin
      access(1'b0, {b[2:0], 15'h7fff}, 8'h00);
      chk("read top", 8'ha0 + 8'(b), rsp_rdata);
      access(1'b0, {b[2:0], 15'h0000}, 8'h00);
      chk("read base", 8'h5f ^ 8'(b), rsp_rdata);
    end
    $display("test banks done");
  endtask

  // a write offered during retention must be refused
  task automatic t_retain;
    int n = 0;
    access(1'b1, 18'h2a5a5, 8'h3c);
    while (req_ready !== 1'b1 && n++ < 100)
      @(negedge clk_sys);
    chk("ready again", 18'h1, 18'(req_ready));
    retain_req = 1'b1;
    repeat (8) @(negedge clk_sys);
    req_wdata = 8'hc3;
    req_valid = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk("retained", 18'h3ff, {retain_ok, bank_select_n, write_n});
    {req_valid, retain_req} = 2'b00;
    access(1'b0, 18'h2a5a5, 8'h00);
    chk("kept byte", 18'h3c, rsp_rdata);
    $display("test retain done");
  endtask

  initial
  begin
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    t_idle();
    t_banks();
    t_retain();
    print_verdict();
  end

  // about four times the expected run
  initial
  begin
    #24000;
    bad_count++;
    print_verdict();
  end
endmodule

bind bsram_host bsram_asserts u_chk (
  .clk_sys       (clk_sys),
  .nrst          (nrst),
  .req_valid     (req_valid),
  .req_ready     (req_ready),
  .req_addr      (req_addr),
  .retain_req    (retain_req),
  .retain_ok     (retain_ok),
  .bank_select_n (bank_select_n),
  .word_addr     (word_addr),
  .write_n       (write_n),
  .output_n      (output_n),
  .data_lines_o  (data_lines_o),
  .data_lines_oe (data_lines_oe)
);

`default_nettype wire
